// ==== verilog/tsw_pkg.sv ====
// task-switch sequencer: shared register map, field positions, op codes and states
// assumes a 16-bit memory holding descriptor tables and task segments, and an APB master
//
// Operation
// - loading task selector fetches its descriptor
// - selector and cache describe running task
// - nested-task flag lives in flags word
// - task-switched flag lives in status word
// - save, load selector, then load registers
// - jump: incoming busy, outgoing not busy
// - jump clears incoming nested flag only
// - call/interrupt: both segments stay busy
// - call/interrupt sets incoming nested flag
// - return switches only when nested flag set
// - task return frees outgoing, clears its flag
// - busy bit in access byte, global table only
// - direct transfer needs target level >= current
package tsw_pkg;

  localparam int TSW_NREG = 8;

  localparam logic [11:0] TSW_A_CTRL = 12'h000;
  localparam logic [11:0] TSW_A_TARGET = 12'h004;
  localparam logic [11:0] TSW_A_STATUS = 12'h008;
  localparam logic [11:0] TSW_A_TRSEL = 12'h00c;
  localparam logic [11:0] TSW_A_CACHE0 = 12'h010;
  localparam logic [11:0] TSW_A_CACHE1 = 12'h014;
  localparam logic [11:0] TSW_A_MSW = 12'h018;
  localparam logic [11:0] TSW_A_CPL = 12'h01c;
  localparam logic [11:0] TSW_A_GDT = 12'h020;
  localparam logic [11:0] TSW_A_REGS = 12'h040;

  localparam logic [2:0] TSW_OP_JUMP = 3'h0;
  localparam logic [2:0] TSW_OP_CALL = 3'h1;
  localparam logic [2:0] TSW_OP_SWINT = 3'h2;
  localparam logic [2:0] TSW_OP_INTERRUPT_RETURN_OP = 3'h3;
  localparam logic [2:0] TSW_OP_LOAD_TR = 3'h4;

  localparam int TSW_NT_BIT = 14;
  localparam int TSW_TSF_BIT = 3;
  localparam int TSW_TI_BIT = 2;
  localparam int TSW_W2_BUSY = 9;
  localparam int TSW_W2_DPL_LO = 13;
  localparam logic [1:0] TSW_ACC_WORD = 2'h2;
  localparam logic [23:0] TSW_TSS_LINK_OFS = 24'h000000;
  localparam logic [23:0] TSW_TSS_REG_OFS = 24'h00000e;

  localparam logic [15:0] TSW_MSW_RST = 16'h0000;
  localparam logic [15:0] TSW_FLAGS_RST = 16'h0000;
  localparam logic [23:0] TSW_GDT_RST = 24'h000000;

  typedef enum logic [10:0] {
    TSW_ST_IDLE = 11'h001,
    TSW_ST_RD_LINK = 11'h002,
    TSW_ST_RD_DESC = 11'h004,
    TSW_ST_CHECK = 11'h008,
    TSW_ST_SAVE = 11'h010,
    TSW_ST_LOAD_TR = 11'h020,
    TSW_ST_LOAD = 11'h040,
    TSW_ST_BUSY_OUT = 11'h080,
    TSW_ST_BUSY_IN = 11'h100,
    TSW_ST_WR_LINK = 11'h200,
    TSW_ST_DONE = 11'h400
  } tsw_state_t;

  // byte address of one word of a descriptor in the global table
  function automatic logic [23:0] tsw_desc_addr(input logic [23:0] global_descriptor_table, input logic [15:0] sel,
                                                input logic [1:0] w);
    tsw_desc_addr = global_descriptor_table + {8'h00, sel[15:3], 3'h0} + {21'h000000, w, 1'b0};
  endfunction

  // segment base held in a three-word descriptor image
  function automatic logic [23:0] tsw_tss_base(input logic [47:0] desc);
    tsw_tss_base = {desc[39:32], desc[31:16]};
  endfunction

endpackage

// ==== verilog/tsw_if.sv ====
// carriers between the sequencer and its memory and register-bus helpers
// assumes all parties run on the same clock
`timescale 1ns/1ps
interface tsw_mem_if;
  logic req;
  logic we;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport seq (output req, we, addr, wdata, input rdata, done);
  modport port (input req, we, addr, wdata, output rdata, done);
endinterface

interface tsw_reg_if;
  logic wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;
  modport port (output wr, addr, wdata, input rdata, hit);
  modport regs (input wr, addr, wdata, output rdata, hit);
endinterface

// ==== verilog/tsw_mem_master.sv ====
// one-word memory master: takes a held request, answers with a one-cycle done
// assumes memory raises ack while req is high and that req may drop right after ack
`timescale 1ns/1ps
module tsw_mem_master (
  input wire logic clk,
  input wire logic rst,
  tsw_mem_if.port m,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  typedef struct packed {
    logic busy;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
  } tsw_mm_t;

  tsw_mm_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    // the guard on done keeps the old request from starting twice
    if (!q.busy && m.req && !q.done) begin
      d.busy = 1'b1;
      d.we = m.we;
      d.addr = m.addr;
      d.wdata = m.wdata;
    end else if (q.busy && mem_ack) begin
      d.busy = 1'b0;
      d.rdata = mem_rdata;
      d.done = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mem_req = q.busy;
  assign mem_we = q.we;
  assign mem_addr = q.addr;
  assign mem_wdata = q.wdata;
  assign m.rdata = q.rdata;
  assign m.done = q.done;
endmodule

// ==== verilog/tsw_apb_port.sv ====
// APB slave front end: one wait-free access, read data captured in the setup cycle
// assumes the register side decodes addr combinationally into rdata and hit
`timescale 1ns/1ps
module tsw_apb_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tsw_reg_if.port r
);
  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } tsw_apb_t;

  tsw_apb_t q, d;

  always_comb begin
    d = q;
    if (psel && !penable) begin
      d.rdata = pwrite ? 32'h00000000 : r.rdata;
      d.err = !r.hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign r.addr = paddr;
  assign r.wdata = pwdata;
  assign r.wr = psel && penable && pwrite && r.hit;
  assign pready = 1'b1;
  assign pslverr = q.err && psel && penable;
  assign prdata = q.rdata;
endmodule

// ==== verilog/tsw_switch.sv ====
// task-switch sequencer top: register file, descriptor cache and switch state machine
// assumes a synchronous 16-bit memory on the same clock and an APB master for software
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module tsw_switch
  import tsw_pkg::*;
#(
  parameter int NREG = TSW_NREG
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [23:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic SWITCH_BUSY
);
  typedef struct packed {
    tsw_state_t st;
    logic [2:0] op;
    logic [15:0] target;
    logic [15:0] tr_sel;
    logic [15:0] old_sel;
    logic [15:0] old_acc;
    logic [47:0] cache;
    logic [47:0] fetch;
    logic [15:0] machine_status_word;
    logic [1:0] current_privilege_level;
    logic [23:0] global_descriptor_table;
    logic [4:0] idx;
    logic priv_fault;
    logic gdt_fault;
    logic task_ret;
    logic [NREG-1:0][15:0] regs;
  } tsw_top_t;

  tsw_top_t q, d;
  tsw_mem_if mi ();
  tsw_reg_if ri ();

  logic [11:0] roff;
  logic [4:0] rix;
  logic in_regs;
  logic last_reg;
  logic is_switch;
  logic ctrl_wr;

  tsw_apb_port u_apb (
    .clk(CLK),
    .rst(SYS_RST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .r(ri.port)
  );

  tsw_mem_master u_mem (
    .clk(CLK),
    .rst(SYS_RST),
    .m(mi.port),
    .mem_req(MEM_REQ),
    .mem_we(MEM_WE),
    .mem_addr(MEM_ADDR),
    .mem_wdata(MEM_WDATA),
    .mem_rdata(MEM_RDATA),
    .mem_ack(MEM_ACK)
  );

  assign roff = ri.addr - TSW_A_REGS;
  assign rix = roff[6:2];
  assign in_regs = (ri.addr >= TSW_A_REGS) && (roff < 12'(4 * NREG)) && (ri.addr[1:0] == 2'h0);
  assign last_reg = (q.idx == 5'(NREG - 1));
  assign is_switch = (q.op == TSW_OP_JUMP) || (q.op == TSW_OP_CALL) || (q.op == TSW_OP_SWINT);
  assign ctrl_wr = ri.wr && (ri.addr == TSW_A_CTRL);

  // register read decode
  always_comb begin
    ri.rdata = 32'h00000000;
    ri.hit = 1'b1;
    case (ri.addr)
      TSW_A_CTRL: ri.rdata = {29'h00000000, q.op};
      TSW_A_TARGET: ri.rdata = {16'h0000, q.target};
      TSW_A_STATUS: ri.rdata = {28'h0000000, q.task_ret, q.gdt_fault, q.priv_fault, q.st != TSW_ST_IDLE};
      TSW_A_TRSEL: ri.rdata = {16'h0000, q.tr_sel};
      TSW_A_CACHE0: ri.rdata = q.cache[31:0];
      TSW_A_CACHE1: ri.rdata = {16'h0000, q.cache[47:32]};
      TSW_A_MSW: ri.rdata = {16'h0000, q.machine_status_word};
      TSW_A_CPL: ri.rdata = {30'h00000000, q.current_privilege_level};
      TSW_A_GDT: ri.rdata = {8'h00, q.global_descriptor_table};
      default: begin
        if (in_regs) begin
          ri.rdata = {16'h0000, q.regs[rix]};
        end else begin
          ri.hit = 1'b0;
        end
      end
    endcase
  end

  // memory request follows the state; held until done
  always_comb begin
    mi.req = 1'b0;
    mi.we = 1'b0;
    mi.addr = 24'h000000;
    mi.wdata = 16'h0000;
    case (q.st)
      TSW_ST_RD_LINK: begin
        mi.req = 1'b1;
        mi.addr = tsw_tss_base(q.cache) + TSW_TSS_LINK_OFS;
      end
      TSW_ST_RD_DESC: begin
        mi.req = !q.target[TSW_TI_BIT];
        mi.addr = tsw_desc_addr(q.global_descriptor_table, q.target, q.idx[1:0]);
      end
      TSW_ST_SAVE: begin
        mi.req = 1'b1;
        mi.we = 1'b1;
        mi.addr = tsw_tss_base(q.cache) + TSW_TSS_REG_OFS + {18'h00000, q.idx, 1'b0};
        mi.wdata = q.regs[q.idx];
        if (q.idx == 5'h00 && q.op == TSW_OP_INTERRUPT_RETURN_OP) begin
          mi.wdata[TSW_NT_BIT] = 1'b0;
        end
      end
      TSW_ST_LOAD: begin
        mi.req = 1'b1;
        mi.addr = tsw_tss_base(q.cache) + TSW_TSS_REG_OFS + {18'h00000, q.idx, 1'b0};
      end
      TSW_ST_BUSY_OUT: begin
        mi.req = 1'b1;
        mi.we = 1'b1;
        mi.addr = tsw_desc_addr(q.global_descriptor_table, q.old_sel, TSW_ACC_WORD);
        mi.wdata = q.old_acc;
        mi.wdata[TSW_W2_BUSY] = 1'b0;
      end
      TSW_ST_BUSY_IN: begin
        mi.req = 1'b1;
        mi.we = 1'b1;
        mi.addr = tsw_desc_addr(q.global_descriptor_table, q.tr_sel, TSW_ACC_WORD);
        mi.wdata = q.cache[47:32];
        mi.wdata[TSW_W2_BUSY] = 1'b1;
      end
      TSW_ST_WR_LINK: begin
        mi.req = 1'b1;
        mi.we = 1'b1;
        mi.addr = tsw_tss_base(q.cache) + TSW_TSS_LINK_OFS;
        mi.wdata = q.old_sel;
      end
      default: mi.req = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    case (q.st)
      TSW_ST_IDLE: begin
        // software writes land only between sequences
        if (ri.wr && in_regs) begin
          d.regs[rix] = ri.wdata[15:0];
        end
        if (ri.wr && ri.addr == TSW_A_TARGET) begin
          d.target = ri.wdata[15:0];
        end
        if (ri.wr && ri.addr == TSW_A_MSW) begin
          d.machine_status_word = ri.wdata[15:0];
        end
        if (ri.wr && ri.addr == TSW_A_CPL) begin
          d.current_privilege_level = ri.wdata[1:0];
        end
        if (ri.wr && ri.addr == TSW_A_GDT) begin
          d.global_descriptor_table = ri.wdata[23:0];
        end
        if (ctrl_wr && ri.wdata[2:0] <= TSW_OP_LOAD_TR) begin
          d.op = ri.wdata[2:0];
          d.idx = 5'h00;
          d.priv_fault = 1'b0;
          d.gdt_fault = 1'b0;
          d.task_ret = 1'b0;
          if (ri.wdata[2:0] != TSW_OP_INTERRUPT_RETURN_OP) begin
            d.st = TSW_ST_RD_DESC;
          end else if (q.regs[0][TSW_NT_BIT]) begin
            d.st = TSW_ST_RD_LINK;
          end else begin
            d.st = TSW_ST_DONE;
          end
        end
      end
      TSW_ST_RD_LINK: begin
        if (mi.done) begin
          d.target = mi.rdata;
          d.st = TSW_ST_RD_DESC;
        end
      end
      TSW_ST_RD_DESC: begin
        if (q.target[TSW_TI_BIT]) begin
          d.gdt_fault = 1'b1;
          d.st = TSW_ST_DONE;
        end else if (mi.done) begin
          d.fetch[q.idx[1:0] * 16 +: 16] = mi.rdata;
          d.idx = q.idx + 5'h01;
          if (q.idx[1:0] == TSW_ACC_WORD) begin
            d.idx = 5'h00;
            d.st = TSW_ST_CHECK;
          end
        end
      end
      TSW_ST_CHECK: begin
        if (q.op == TSW_OP_LOAD_TR) begin
          d.st = TSW_ST_LOAD_TR;
        end else if (q.op != TSW_OP_INTERRUPT_RETURN_OP && q.fetch[32 + TSW_W2_DPL_LO +: 2] < q.current_privilege_level) begin
          d.priv_fault = 1'b1;
          d.st = TSW_ST_DONE;
        end else begin
          d.st = TSW_ST_SAVE;
        end
      end
      TSW_ST_SAVE: begin
        if (mi.done) begin
          d.idx = q.idx + 5'h01;
          if (last_reg) begin
            d.idx = 5'h00;
            d.st = TSW_ST_LOAD_TR;
          end
        end
      end
      TSW_ST_LOAD_TR: begin
        // the old selector and access word are kept to free the outgoing segment later
        d.old_sel = q.tr_sel;
        d.old_acc = q.cache[47:32];
        d.tr_sel = q.target;
        d.cache = q.fetch;
        d.st = (q.op == TSW_OP_LOAD_TR) ? TSW_ST_DONE : TSW_ST_LOAD;
      end
      TSW_ST_LOAD: begin
        if (mi.done) begin
          d.regs[q.idx] = mi.rdata;
          if (q.idx == 5'h00 && q.op == TSW_OP_JUMP) begin
            d.regs[0][TSW_NT_BIT] = 1'b0;
          end
          if (q.idx == 5'h00 && (q.op == TSW_OP_CALL || q.op == TSW_OP_SWINT)) begin
            d.regs[0][TSW_NT_BIT] = 1'b1;
          end
          d.idx = q.idx + 5'h01;
          if (last_reg) begin
            d.idx = 5'h00;
            d.st = (q.op == TSW_OP_CALL || q.op == TSW_OP_SWINT) ? TSW_ST_BUSY_IN : TSW_ST_BUSY_OUT;
          end
        end
      end
      TSW_ST_BUSY_OUT: begin
        if (mi.done) begin
          d.task_ret = (q.op == TSW_OP_INTERRUPT_RETURN_OP);
          d.st = (q.op == TSW_OP_INTERRUPT_RETURN_OP) ? TSW_ST_DONE : TSW_ST_BUSY_IN;
        end
      end
      TSW_ST_BUSY_IN: begin
        if (mi.done) begin
          d.cache[32 + TSW_W2_BUSY] = 1'b1;
          d.st = (q.op == TSW_OP_JUMP) ? TSW_ST_DONE : TSW_ST_WR_LINK;
        end
      end
      TSW_ST_WR_LINK: begin
        if (mi.done) begin
          d.st = TSW_ST_DONE;
        end
      end
      TSW_ST_DONE: begin
        if (is_switch && !q.priv_fault && !q.gdt_fault) begin
          d.machine_status_word[TSW_TSF_BIT] = 1'b1;
        end
        d.st = TSW_ST_IDLE;
      end
      default: d.st = TSW_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= '0;
      q.st <= TSW_ST_IDLE;
      q.machine_status_word <= TSW_MSW_RST;
      q.global_descriptor_table <= TSW_GDT_RST;
      q.regs[0] <= TSW_FLAGS_RST;
    end else begin
      q <= d;
    end
  end

  assign SWITCH_BUSY = (q.st != TSW_ST_IDLE);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_save_last;
    q.st == TSW_ST_SAVE && mi.done && last_reg;
  endsequence

  sequence s_tr_then_load;
    q.st == TSW_ST_LOAD_TR ##1 q.st == TSW_ST_LOAD;
  endsequence

  property p_tr_cache;
    q.st == TSW_ST_LOAD_TR |=> q.tr_sel == $past(q.target) && q.cache == $past(q.fetch);
  endproperty
  a_tr_cache: assert property (p_tr_cache) else $error("selector or cache not loaded");

  property p_order;
    s_save_last and (q.op != TSW_OP_LOAD_TR) |=> s_tr_then_load;
  endproperty
  a_order: assert property (p_order) else $error("save, selector, load out of order");

  property p_jump_nt;
    q.st == TSW_ST_LOAD && mi.done && q.idx == 5'h00 && q.op == TSW_OP_JUMP |=> !q.regs[0][TSW_NT_BIT];
  endproperty
  a_jump_nt: assert property (p_jump_nt) else $error("jump left incoming nested flag set");

  property p_call_nt;
    q.st == TSW_ST_LOAD && mi.done && q.idx == 5'h00 && q.op == TSW_OP_CALL |=> q.regs[0][TSW_NT_BIT];
  endproperty
  a_call_nt: assert property (p_call_nt) else $error("call did not set incoming nested flag");

  property p_tsf;
    q.st == TSW_ST_DONE && is_switch && !q.priv_fault && !q.gdt_fault |=> q.machine_status_word[TSW_TSF_BIT];
  endproperty
  a_tsf: assert property (p_tsf) else $error("task-switched flag not set");

  property p_interrupt_return_op_plain;
    q.st == TSW_ST_IDLE && ctrl_wr && ri.wdata[2:0] == TSW_OP_INTERRUPT_RETURN_OP && !q.regs[0][TSW_NT_BIT]
      |=> q.st == TSW_ST_DONE ##1 q.st == TSW_ST_IDLE;
  endproperty
  a_interrupt_return_op_plain: assert property (p_interrupt_return_op_plain) else $error("plain return touched memory");

  property p_busy_out;
    q.st == TSW_ST_BUSY_OUT |-> mi.we && !mi.wdata[TSW_W2_BUSY]
      && mi.addr == tsw_desc_addr(q.global_descriptor_table, q.old_sel, TSW_ACC_WORD);
  endproperty
  a_busy_out: assert property (p_busy_out) else $error("outgoing busy mark not cleared");

  property p_busy_in;
    q.st == TSW_ST_BUSY_IN |-> mi.we && mi.wdata[TSW_W2_BUSY] && q.op != TSW_OP_INTERRUPT_RETURN_OP;
  endproperty
  a_busy_in: assert property (p_busy_in) else $error("incoming busy mark wrong");

  property p_interrupt_return_op_save_nt;
    q.st == TSW_ST_SAVE && q.idx == 5'h00 && q.op == TSW_OP_INTERRUPT_RETURN_OP |-> !mi.wdata[TSW_NT_BIT];
  endproperty
  a_interrupt_return_op_save_nt: assert property (p_interrupt_return_op_save_nt) else $error("outgoing nested flag kept");

  property p_priv;
    q.st == TSW_ST_CHECK && is_switch && q.fetch[32 + TSW_W2_DPL_LO +: 2] < q.current_privilege_level
      |=> q.priv_fault && q.st == TSW_ST_DONE ##1 q.st == TSW_ST_IDLE;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege fault not taken");

  property p_local_refused;
    q.st == TSW_ST_RD_DESC && q.target[TSW_TI_BIT] |-> !mi.req ##1 q.gdt_fault;
  endproperty
  a_local_refused: assert property (p_local_refused) else $error("local table descriptor used");

  property p_atomic;
    q.st != TSW_ST_IDLE && q.st != TSW_ST_DONE && ctrl_wr |=> q.st != TSW_ST_IDLE && $stable(q.op);
  endproperty
  a_atomic: assert property (p_atomic) else $error("sequence disturbed by software");
endmodule

// ==== verif/tsw_mem_model.sv ====
// memory partner: 16-bit word store holding descriptor tables and task segments
// assumes one request at a time, held until acknowledged, on the same clock
`timescale 1ns/1ps
module tsw_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic we,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] delay,
  output logic [15:0] rdata,
  output logic ack
);
  logic [15:0] mem [0:4095];
  logic [3:0] cnt_q;
  // plain always: the bench preloads and inspects mem directly
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
      rdata <= 16'h0000;
    end else if (req && !ack && cnt_q >= delay) begin
      ack <= 1'b1;
      cnt_q <= 4'h0;
      if (we) begin
        mem[addr[12:1]] <= wdata;
      end else begin
        rdata <= mem[addr[12:1]];
      end
    end else begin
      ack <= 1'b0;
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
      // a released data bus never repeats the last word
      rdata <= ~rdata;
    end
  end
endmodule

// ==== verif/tsw_switch_tb_top.sv ====
// bench for the task-switch sequencer: APB master tasks, memory partner, one task per scenario
// assumes the map of tsw_pkg, gdt at 0x100, task k at selector 8k with segment base 0x300+0x100k
`timescale 1ns/1ps
module tsw_switch_tb_top;
  import tsw_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, mreq, mwe, mack, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] maddr;
  logic [15:0] mwdata, mrdata;
  logic [3:0] mdly;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [31:0] fm = 32'hffffffff;

  tsw_switch dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MEM_REQ(mreq), .MEM_WE(mwe),
    .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_RDATA(mrdata), .MEM_ACK(mack), .SWITCH_BUSY(busy));
  tsw_mem_model mem_i (.clk(clk), .rst(rst), .req(mreq), .we(mwe), .addr(maddr), .wdata(mwdata),
    .delay(mdly), .rdata(mrdata), .ack(mack));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hung switch ends the run here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // the wait on pready has no limit of its own; the cycle ceiling ends a hung access
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(nm, q & m, exp);
  endtask

  function automatic logic [15:0] mw(input logic [23:0] a);
    return mem_i.mem[a[12:1]];
  endfunction

  task automatic go(input logic [2:0] op, input logic [15:0] sel);
    wr(TSW_A_TARGET, {16'h0, sel});
    wr(TSW_A_CTRL, {29'h0, op});
  endtask

  // the busy flag is registered, so give it time to rise before waiting on it
  task automatic settle();
    repeat (3) @(posedge clk);
    while (busy !== 1'b0) begin
      @(posedge clk);
    end
  endtask

  task automatic t_reset();
    rchk("msw", TSW_A_MSW, fm, 32'h0);
    rchk("trsel", TSW_A_TRSEL, fm, 32'h0);
    rchk("cpl", TSW_A_CPL, fm, 32'h0);
    rchk("gdt", TSW_A_GDT, fm, 32'h0);
    chk("pready", {31'h0, pready}, 32'h1);
  endtask

  task automatic t_load();
    wr(TSW_A_GDT, 32'h100);
    go(TSW_OP_LOAD_TR, 16'h0008);
    settle();
    rchk("trsel", TSW_A_TRSEL, fm, 32'h8);
    rchk("cache0", TSW_A_CACHE0, fm, 32'h0400002b);
    rchk("cache1", TSW_A_CACHE1, fm, 32'h8300);
  endtask

  task automatic t_jump();
    for (int i = 0; i < TSW_NREG; i++) wr(TSW_A_REGS + 12'(4 * i), (i == 0) ? 32'h0202 : 32'(16'h1000 + i));
    go(TSW_OP_JUMP, 16'h0010);
    settle();
    for (int i = 0; i < TSW_NREG; i++) begin
      chk("save", {16'h0, mw(24'h40e + 24'(2 * i))}, (i == 0) ? 32'h0202 : 32'(16'h1000 + i));
      rchk("reg", TSW_A_REGS + 12'(4 * i), fm, (i == 0) ? 32'h0002 : 32'(16'h2000 + i));
    end
    rchk("trsel", TSW_A_TRSEL, fm, 32'h10);
    chk("busy_out", {16'h0, mw(24'h10c)}, 32'h8100);
    chk("busy_in", {16'h0, mw(24'h114)}, 32'h8300);
    rchk("tsf", TSW_A_MSW, 32'h8, 32'h8);
    rchk("cache1", TSW_A_CACHE1, fm, 32'h8300);
  endtask

  task automatic t_call();
    wr(TSW_A_MSW, 32'h0);
    wr(TSW_A_REGS, 32'h4002);
    go(TSW_OP_CALL, 16'h0018);
    settle();
    chk("save_nt", {16'h0, mw(24'h50e)}, 32'h4002);
    chk("busy_out", {16'h0, mw(24'h114)}, 32'h8300);
    chk("busy_in", {16'h0, mw(24'h11c)}, 32'h8300);
    rchk("nt", TSW_A_REGS, fm, 32'h4002);
    rchk("reg1", TSW_A_REGS + 12'h4, fm, 32'h3001);
    rchk("tsf", TSW_A_MSW, 32'h8, 32'h8);
    rchk("trsel", TSW_A_TRSEL, fm, 32'h18);
    chk("link", {16'h0, mw(24'h600)}, 32'h10);
  endtask

  task automatic t_interrupt_return_op_task();
    wr(TSW_A_MSW, 32'h0);
    go(TSW_OP_INTERRUPT_RETURN_OP, 16'h0000);
    settle();
    rchk("trsel", TSW_A_TRSEL, fm, 32'h10);
    chk("save_nt", {16'h0, mw(24'h60e)}, 32'h0002);
    chk("save1", {16'h0, mw(24'h610)}, 32'h3001);
    chk("busy_out", {16'h0, mw(24'h11c)}, 32'h8100);
    rchk("nt_in", TSW_A_REGS, fm, 32'h4002);
    rchk("ret", TSW_A_STATUS, 32'h8, 32'h8);
    rchk("tsf_kept", TSW_A_MSW, 32'h8, 32'h0);
  endtask

  // slow memory keeps the switch running while software tries to write
  task automatic t_swint_slow();
    mdly <= 4'h3;
    wr(TSW_A_MSW, 32'h0);
    go(TSW_OP_SWINT, 16'h0018);
    wr(TSW_A_CPL, 32'h2);
    wr(TSW_A_CTRL, {29'h0, TSW_OP_LOAD_TR});
    rchk("busy", TSW_A_STATUS, 32'h1, 32'h1);
    chk("busy_pin", {31'h0, busy}, 32'h1);
    settle();
    mdly <= 4'h0;
    rchk("cpl", TSW_A_CPL, fm, 32'h0);
    rchk("op", TSW_A_CTRL, fm, 32'h2);
    chk("busy_out", {16'h0, mw(24'h114)}, 32'h8300);
    chk("busy_in", {16'h0, mw(24'h11c)}, 32'h8300);
    rchk("nt", TSW_A_REGS, fm, 32'h4002);
    rchk("tsf", TSW_A_MSW, 32'h8, 32'h8);
  endtask

  task automatic t_interrupt_return_op_plain();
    wr(TSW_A_REGS, 32'h0);
    go(TSW_OP_INTERRUPT_RETURN_OP, 16'h0000);
    settle();
    rchk("trsel", TSW_A_TRSEL, fm, 32'h18);
    rchk("ret", TSW_A_STATUS, 32'h8, 32'h0);
    chk("busy", {16'h0, mw(24'h11c)}, 32'h8300);
  endtask

  task automatic t_faults();
    logic [31:0] q;
    logic e;
    wr(TSW_A_CPL, 32'h1);
    go(TSW_OP_JUMP, 16'h0020);
    settle();
    rchk("priv", TSW_A_STATUS, 32'h2, 32'h2);
    rchk("trsel", TSW_A_TRSEL, fm, 32'h18);
    chk("busy", {16'h0, mw(24'h124)}, 32'h8100);
    wr(TSW_A_CPL, 32'h0);
    go(TSW_OP_JUMP, 16'h000c);
    settle();
    rchk("table", TSW_A_STATUS, 32'h4, 32'h4);
    rchk("trsel", TSW_A_TRSEL, fm, 32'h18);
    xfer(1'b0, 12'h024, 32'h0, q, e);
    chk("slverr", {31'h0, e}, 32'h1);
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mdly = 4'h0;
    for (int k = 1; k < 5; k++) begin
      mem_i.mem[(24'h100 + 24'(8 * k)) >> 1] = 16'h002b;
      mem_i.mem[(24'h102 + 24'(8 * k)) >> 1] = 16'(16'h300 + 16'h100 * k);
      mem_i.mem[(24'h104 + 24'(8 * k)) >> 1] = (k == 1) ? 16'h8300 : 16'h8100;
      for (int i = 0; i < TSW_NREG; i++)
        mem_i.mem[(24'h30e + 24'(16'h100 * k + 2 * i)) >> 1] =
          (i == 0) ? ((k == 2) ? 16'h4002 : 16'h0002) : 16'(16'h1000 * k + i);
    end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_load();
    t_jump();
    t_call();
    t_interrupt_return_op_task();
    t_swint_slow();
    t_interrupt_return_op_plain();
    t_faults();
    wrap_up();
  end
endmodule
